// >>> rtl/ssm_regs.svh
// Register offsets, field positions, reset values and rate constants of the
// synthesizer serial pin-mode block. Included by the clock divider, the top level and the testbench.
`ifndef SSM_REGS_SVH
`define SSM_REGS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define SSM_CTRL_ADDR  8'h00
`define SSM_PROG_ADDR  8'h04
`define SSM_WORD_ADDR  8'h08
`define SSM_CNT_ADDR   8'h0C
`define SSM_CMD_ADDR   8'h10

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define SSM_CTRL_POL   7
`define SSM_CTRL_ETYPE 6
`define SSM_CTRL_EDGE  5
`define SSM_CTRL_LDB   2
`define SSM_CTRL_LDA   1
`define SSM_CTRL_RATE  0
`define SSM_PROG_DISB  5
`define SSM_PROG_DISA  4
`define SSM_CMD_START  0
`define SSM_CTRL_RST   8'h00
`define SSM_PROG_RST   8'h00
`define SSM_WORD_RST   32'h00000000
`define SSM_CNT_RST    6'h20
`define SSM_CNT_MAX    6'h20

// ----------------------------------------------------------------------------
// Serial clock rates
// ----------------------------------------------------------------------------
`define SSM_PCLK_HZ    125000000
`define SSM_SLOW_HZ    1625000
`define SSM_FAST_HZ    6500000
`define SSM_SLOW_HALF  (`SSM_PCLK_HZ / (2 * `SSM_SLOW_HZ))
`define SSM_FAST_HALF  (`SSM_PCLK_HZ / (2 * `SSM_FAST_HZ))

`endif

// >>> rtl/ssm_pkg.sv
// Types shared by the synthesizer serial pin-mode block.
// Assumes nothing beyond a SystemVerilog compiler.
package ssm_pkg;

    typedef enum logic [2:0] {
        SSM_ST_IDLE  = 3'h1,
        SSM_ST_SHIFT = 3'h2,
        SSM_ST_PULSE = 3'h4
    } ssm_state_type;

    typedef enum logic [1:0] {
        SSM_MODE1 = 2'h1,
        SSM_MODE2 = 2'h2,
        SSM_MODE3 = 2'h3
    } ssm_mode_type;

endpackage

// >>> rtl/ssm_clk_if.sv
// Handshake between the serial engine and its half-period tick divider.
// Assumes both ends run on pclk.
`timescale 1ns/10ps
interface ssm_clk_if;
    logic run;
    logic fast;
    logic tick;
    modport gen  (input run, input fast, output tick);
    modport user (output run, output fast, input tick);
endinterface

// >>> rtl/ssm_clkgen.sv
// Divider that gives a one-cycle tick every half period of the serial clock.
// Assumes run and fast stay steady while a transfer is in progress.
`timescale 1ns/10ps
`include "ssm_regs.svh"
module ssm_clkgen (
    input  wire logic pclk,
    input  wire logic presetn,
    ssm_clk_if.gen    ck
);
    import ssm_pkg::*;

    logic [5:0] cnt_ff;
    logic [5:0] nxt_cnt;
    logic       tick_ff;
    logic       nxt_tick;
    logic [5:0] half;
    logic [5:0] gap_ff;

    // The count restarts whenever run drops, so the first edge of a frame
    // always comes a full half period after the data is presented.
    always_comb begin
        nxt_cnt  = 6'h00;
        nxt_tick = 1'b0;
        half     = ck.fast ? 6'(`SSM_FAST_HALF - 1) : 6'(`SSM_SLOW_HALF - 1);
        if (ck.run) begin
            if (cnt_ff == half) begin
                nxt_tick = 1'b1;
            end else begin
                nxt_cnt = cnt_ff + 6'h01;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff  <= 6'h00;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign ck.tick = tick_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_ff <= 6'h00;
        end else if (!ck.run) begin
            gap_ff <= 6'h00;
        end else if (tick_ff) begin
            gap_ff <= 6'h01;
        end else begin
            gap_ff <= gap_ff + 6'h01;
        end
    end

    half_period_a: assert property (@(posedge pclk) disable iff (!presetn)
        tick_ff && ck.run |-> gap_ff == (ck.fast ? 6'(`SSM_FAST_HALF) : 6'(`SSM_SLOW_HALF)))
        else $error("Serial clock half period is wrong.");

endmodule

// >>> rtl/ssm_top.sv
// Synthesizer serial interface with pin-mode multiplexing onto DSP flags.
// Assumes an APB master on pclk and DSP flags driven by logic on pclk.
`timescale 1ns/10ps
`include "ssm_regs.svh"

module ssm_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        dsp_out_flag_a,
    input  wire logic        dsp_out_flag_b,
    input  wire logic        dsp_out_flag_c,
    output logic             pll_serial_out,
    output logic             pll_serial_clk,
    output logic             pll_enable_a,
    output logic             pll_enable_b,
    output logic             gain_select_lo,
    output logic             gain_select_hi
);
    import ssm_pkg::*;

    function automatic ssm_mode_type pin_mode(input logic [1:0] code);
        pin_mode = code[1] ? (code[0] ? SSM_MODE3 : SSM_MODE2) : SSM_MODE1;
    endfunction

    function automatic logic [5:0] bit_count(input logic [5:0] cnt);
        bit_count = (cnt == 6'h00 || cnt > `SSM_CNT_MAX) ? `SSM_CNT_MAX : cnt;
    endfunction

    // ------------------------------------------------------------------------
    // APB slave and registers
    // ------------------------------------------------------------------------
    logic [7:0]  ctrl_ff;
    logic [7:0]  nxt_ctrl;
    logic [7:0]  prog_ff;
    logic [7:0]  nxt_prog;
    logic [31:0] word_ff;
    logic [31:0] nxt_word;
    logic [5:0]  cnt_ff;
    logic [5:0]  nxt_cnt;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic        pready_ff;
    logic        nxt_pready;
    logic        pslverr_ff;
    logic        nxt_pslverr;
    logic        wr;
    logic        start;
    logic        busy;
    ssm_mode_type  mode;
    ssm_state_type state_ff;

    // One wait state: the answer is prepared in the first access cycle and
    // the write lands on the edge where pready is seen high.
    always_comb begin
        nxt_ctrl    = ctrl_ff;
        nxt_prog    = prog_ff;
        nxt_word    = word_ff;
        nxt_cnt     = cnt_ff;
        nxt_prdata  = prdata_ff;
        nxt_pslverr = 1'b0;
        nxt_pready  = psel && penable && !pready_ff;
        wr          = psel && penable && pready_ff && pwrite;
        start       = 1'b0;
        if (nxt_pready) begin
            nxt_prdata = 32'h00000000;
            case (paddr)
                `SSM_CTRL_ADDR: nxt_prdata = {24'h000000, ctrl_ff};
                `SSM_PROG_ADDR: nxt_prdata = {24'h000000, prog_ff};
                `SSM_WORD_ADDR: nxt_prdata = word_ff;
                `SSM_CNT_ADDR:  nxt_prdata = {26'h0000000, cnt_ff};
                `SSM_CMD_ADDR:  nxt_prdata = {29'h00000000, mode, busy};
                default:        nxt_pslverr = 1'b1;
            endcase
        end
        if (wr) begin
            case (paddr)
                `SSM_CTRL_ADDR: nxt_ctrl = pwdata[7:0];
                `SSM_PROG_ADDR: nxt_prog = pwdata[7:0];
                `SSM_WORD_ADDR: nxt_word = pwdata;
                `SSM_CNT_ADDR:  nxt_cnt  = pwdata[5:0];
                `SSM_CMD_ADDR:  start    = pwdata[`SSM_CMD_START] && !busy;
                default:        start    = 1'b0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff    <= `SSM_CTRL_RST;
            prog_ff    <= `SSM_PROG_RST;
            word_ff    <= `SSM_WORD_RST;
            cnt_ff     <= `SSM_CNT_RST;
            prdata_ff  <= 32'h00000000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            ctrl_ff    <= nxt_ctrl;
            prog_ff    <= nxt_prog;
            word_ff    <= nxt_word;
            cnt_ff     <= nxt_cnt;
            prdata_ff  <= nxt_prdata;
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    assign prdata  = prdata_ff;
    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;
    assign mode    = pin_mode(prog_ff[1:0]);

    // ------------------------------------------------------------------------
    // Serial engine
    // ------------------------------------------------------------------------
    ssm_clk_if ck ();

    ssm_clkgen u_clkgen (
        .pclk    (pclk),
        .presetn (presetn),
        .ck      (ck)
    );

    logic [31:0] shift_ff;
    logic [31:0] nxt_shift;
    logic [5:0]  left_ff;
    logic [5:0]  nxt_left;
    logic        data_ff;
    logic        nxt_data;
    logic        sclk_ff;
    logic        nxt_sclk;
    logic        phase_ff;
    logic        nxt_phase;
    logic        idle_ff;
    logic        nxt_idle;
    logic        etype_ff;
    logic        nxt_etype;
    logic        rate_ff;
    logic        nxt_rate;
    logic        sel_a_ff;
    logic        nxt_sel_a;
    logic        sel_b_ff;
    logic        nxt_sel_b;
    logic        pol_a_ff;
    logic        nxt_pol_a;
    logic        pol_b_ff;
    logic        nxt_pol_b;
    logic        en_a_ff;
    logic        nxt_en_a;
    logic        en_b_ff;
    logic        nxt_en_b;
    logic        en_on;
    ssm_state_type nxt_state;

    assign busy    = state_ff != SSM_ST_IDLE;
    assign ck.run  = busy;
    assign ck.fast = rate_ff;

    // Each bit spans two half periods: the clock leaves its idle level on
    // the capture edge and returns to it on the launch edge, so the idle
    // level equals the launch polarity.
    always_comb begin
        nxt_state = state_ff;
        nxt_shift = shift_ff;
        nxt_left  = left_ff;
        nxt_data  = data_ff;
        nxt_sclk  = sclk_ff;
        nxt_phase = phase_ff;
        nxt_idle  = idle_ff;
        nxt_etype = etype_ff;
        nxt_rate  = rate_ff;
        nxt_sel_a = sel_a_ff;
        nxt_sel_b = sel_b_ff;
        nxt_pol_a = pol_a_ff;
        nxt_pol_b = pol_b_ff;
        case (state_ff)
            SSM_ST_IDLE: begin
                nxt_sclk = ctrl_ff[`SSM_CTRL_EDGE];
                if (start) begin
                    nxt_state = SSM_ST_SHIFT;
                    nxt_sel_a = ctrl_ff[`SSM_CTRL_LDA] && !prog_ff[`SSM_PROG_DISA];
                    nxt_sel_b = ctrl_ff[`SSM_CTRL_LDB] && !prog_ff[`SSM_PROG_DISB];
                    if (ctrl_ff[`SSM_CTRL_LDA]) begin
                        nxt_pol_a = ctrl_ff[`SSM_CTRL_POL];
                    end
                    if (ctrl_ff[`SSM_CTRL_LDB]) begin
                        nxt_pol_b = ctrl_ff[`SSM_CTRL_POL];
                    end
                    nxt_etype = ctrl_ff[`SSM_CTRL_ETYPE];
                    nxt_rate  = ctrl_ff[`SSM_CTRL_RATE];
                    nxt_idle  = ctrl_ff[`SSM_CTRL_EDGE];
                    nxt_shift = word_ff;
                    nxt_data  = word_ff[31];
                    nxt_left  = bit_count(cnt_ff);
                    nxt_phase = 1'b0;
                end
            end
            SSM_ST_SHIFT: begin
                if (ck.tick) begin
                    nxt_phase = !phase_ff;
                    nxt_sclk  = phase_ff ? idle_ff : !idle_ff;
                    if (phase_ff) begin
                        if (left_ff == 6'h01) begin
                            nxt_state = etype_ff ? SSM_ST_PULSE : SSM_ST_IDLE;
                        end else begin
                            nxt_shift = {shift_ff[30:0], 1'b0};
                            nxt_data  = shift_ff[30];
                            nxt_left  = left_ff - 6'h01;
                        end
                    end
                end
            end
            SSM_ST_PULSE: begin
                // The clock rests at its idle level during the enable pulse, so the
                // receiver sees no edge beyond the configured bit count.
                if (ck.tick) begin
                    nxt_phase = !phase_ff;
                    if (phase_ff) begin
                        nxt_state = SSM_ST_IDLE;
                    end
                end
            end
            default: begin
                nxt_state = SSM_ST_IDLE;
            end
        endcase
        en_on = (nxt_state == SSM_ST_SHIFT && !nxt_etype) ||
                (nxt_state == SSM_ST_PULSE);
        nxt_en_a = (nxt_sel_a && en_on) ? nxt_pol_a : !nxt_pol_a;
        nxt_en_b = (nxt_sel_b && en_on) ? nxt_pol_b : !nxt_pol_b;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= SSM_ST_IDLE;
            shift_ff <= 32'h00000000;
            left_ff  <= 6'h00;
            data_ff  <= 1'b0;
            sclk_ff  <= 1'b0;
            phase_ff <= 1'b0;
            idle_ff  <= 1'b0;
            etype_ff <= 1'b0;
            rate_ff  <= 1'b0;
            sel_a_ff <= 1'b0;
            sel_b_ff <= 1'b0;
            pol_a_ff <= 1'b0;
            pol_b_ff <= 1'b0;
            en_a_ff  <= 1'b1;
            en_b_ff  <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            shift_ff <= nxt_shift;
            left_ff  <= nxt_left;
            data_ff  <= nxt_data;
            sclk_ff  <= nxt_sclk;
            phase_ff <= nxt_phase;
            idle_ff  <= nxt_idle;
            etype_ff <= nxt_etype;
            rate_ff  <= nxt_rate;
            sel_a_ff <= nxt_sel_a;
            sel_b_ff <= nxt_sel_b;
            pol_a_ff <= nxt_pol_a;
            pol_b_ff <= nxt_pol_b;
            en_a_ff  <= nxt_en_a;
            en_b_ff  <= nxt_en_b;
        end
    end

    // ------------------------------------------------------------------------
    // Pin multiplexing
    // ------------------------------------------------------------------------
    logic out_ff;
    logic nxt_out;
    logic clk_ff;
    logic nxt_clk;
    logic ena_ff;
    logic enb_ff;
    logic lo_ff;
    logic nxt_lo;
    logic hi_ff;
    logic nxt_hi;

    // The third mode's offset-correction output is not built here, so its
    // pin holds low rather than floating.
    always_comb begin
        nxt_out = data_ff;
        nxt_clk = sclk_ff;
        nxt_lo  = dsp_out_flag_a;
        nxt_hi  = dsp_out_flag_b;
        case (mode)
            SSM_MODE1: begin
                nxt_out = data_ff;
                nxt_clk = sclk_ff;
                nxt_lo  = dsp_out_flag_a;
                nxt_hi  = dsp_out_flag_b;
            end
            SSM_MODE2: begin
                nxt_out = busy ? data_ff : dsp_out_flag_b;
                nxt_clk = busy ? sclk_ff : dsp_out_flag_c;
                nxt_lo  = busy ? (en_b_ff & dsp_out_flag_a) : dsp_out_flag_a;
                nxt_hi  = dsp_out_flag_b;
            end
            SSM_MODE3: begin
                nxt_out = busy ? data_ff : dsp_out_flag_b;
                nxt_clk = busy ? sclk_ff : dsp_out_flag_c;
                nxt_lo  = dsp_out_flag_a;
                nxt_hi  = 1'b0;
            end
            default: begin
                nxt_out = data_ff;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_ff <= 1'b0;
            clk_ff <= 1'b0;
            ena_ff <= 1'b1;
            enb_ff <= 1'b1;
            lo_ff  <= 1'b0;
            hi_ff  <= 1'b0;
        end else begin
            out_ff <= nxt_out;
            clk_ff <= nxt_clk;
            ena_ff <= en_a_ff;
            enb_ff <= en_b_ff;
            lo_ff  <= nxt_lo;
            hi_ff  <= nxt_hi;
        end
    end

    assign pll_serial_out = out_ff;
    assign pll_serial_clk = clk_ff;
    assign pll_enable_a   = ena_ff;
    assign pll_enable_b   = enb_ff;
    assign gain_select_lo = lo_ff;
    assign gain_select_hi = hi_ff;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    enable_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_ff == SSM_ST_IDLE |-> en_a_ff == !pol_a_ff && en_b_ff == !pol_b_ff)
        else $error("Enable not at inactive level while idle.");

    mode_decode_a: assert property (@(posedge pclk) disable iff (!presetn)
        prog_ff[1] == 1'b0 |-> mode == SSM_MODE1)
        else $error("Low pin-mode codes must give mode 1.");

    mode1_pins_a: assert property (@(posedge pclk) disable iff (!presetn)
        mode == SSM_MODE1 |=> pll_serial_out == $past(data_ff) &&
                              pll_serial_clk == $past(sclk_ff))
        else $error("Mode 1 serial pins not carrying serial data and clock.");

    launch_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_ff == SSM_ST_SHIFT && $changed(data_ff) |-> sclk_ff == idle_ff)
        else $error("Data changed on the capture edge.");

    idle_data_a: assert property (@(posedge pclk) disable iff (!presetn)
        mode != SSM_MODE1 && !busy |=> pll_serial_out == $past(dsp_out_flag_b))
        else $error("Idle data pin does not show flag b.");

    idle_clock_a: assert property (@(posedge pclk) disable iff (!presetn)
        mode != SSM_MODE1 && !busy |=> pll_serial_clk == $past(dsp_out_flag_c))
        else $error("Idle clock pin does not show flag c.");

    gain_mode1_a: assert property (@(posedge pclk) disable iff (!presetn)
        mode == SSM_MODE1 |=> gain_select_lo == $past(dsp_out_flag_a) &&
                              gain_select_hi == $past(dsp_out_flag_b))
        else $error("Mode 1 gain pins do not follow flags a and b.");

    gain_shared_a: assert property (@(posedge pclk) disable iff (!presetn)
        mode == SSM_MODE2 && busy |=> gain_select_lo == $past(en_b_ff & dsp_out_flag_a))
        else $error("Mode 2 gain low pin not gated enable b.");

    enable_type_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_ff == SSM_ST_SHIFT && sel_a_ff |-> en_a_ff == (etype_ff ? !pol_a_ff : pol_a_ff))
        else $error("Enable level during bits disagrees with enable type.");

    busy_end_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(busy) |-> $past(phase_ff) && $past(ck.tick) &&
                        ($past(state_ff) == SSM_ST_PULSE || !etype_ff))
        else $error("Interface went idle before the enable pulse ended.");

endmodule

// >>> tb/ssm_pll_model.sv
// Behavioural synthesizer receiver on the far side of the serial pins.
// Assumes the pins are sampled on pclk and settings stay steady in a frame.
`timescale 1ns/10ps
module ssm_pll_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clr,
    input  wire logic        launch_rise,
    input  wire logic        pol,
    input  wire logic        sclk,
    input  wire logic        sdata,
    input  wire logic        en,
    output logic      [31:0] word,
    output logic      [5:0]  caps,
    output logic      [5:0]  en_caps,
    output logic      [7:0]  half,
    output logic             en_seen
);
    logic       sclk_q;
    logic [7:0] cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_q <= 1'b0;
            cnt <= 8'h00;
            half <= 8'h00;
            word <= 32'h0;
            caps <= 6'h0;
            en_caps <= 6'h0;
            en_seen <= 1'b0;
        end else begin
            sclk_q <= sclk;
            cnt <= (sclk != sclk_q) ? 8'h01 : cnt + 8'h01;
            if (sclk != sclk_q) half <= cnt;
            if (clr) begin
                word <= 32'h0;
                caps <= 6'h0;
                en_caps <= 6'h0;
                en_seen <= 1'b0;
            end else begin
                if (en == pol) en_seen <= 1'b1;
                // Capture on the edge opposite to the launch edge.
                if (sclk != sclk_q && sclk != launch_rise) begin
                    word <= {word[30:0], sdata};
                    caps <= caps + 6'h1;
                    en_caps <= en_caps + {5'h0, en == pol};
                end
            end
        end
    end
endmodule

// >>> tb/ssm_top_tb.sv
// Self-checking bench: APB register tasks, serial transfers, pin muxing.
// Assumes the design answers APB with a bounded number of wait states.
`timescale 1ns/10ps
`include "ssm_regs.svh"
module ssm_top_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, pw;
    logic pready, pslverr, err, fa = 0, fb = 0, fc = 0, clr = 0, lr = 0, pol = 0, wb = 0;
    logic so, sc, ena, enb, glo, ghi, es;
    logic [5:0] caps, ecaps;
    logic [7:0] half;
    int num_errors = 0, compares = 0;
    always #4 pclk = ~pclk;
    ssm_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .dsp_out_flag_a(fa),
        .dsp_out_flag_b(fb), .dsp_out_flag_c(fc), .pll_serial_out(so),
        .pll_serial_clk(sc), .pll_enable_a(ena), .pll_enable_b(enb),
        .gain_select_lo(glo), .gain_select_hi(ghi));
    ssm_pll_model pll (.pclk(pclk), .presetn(presetn), .clr(clr), .launch_rise(lr),
        .pol(pol), .sclk(sc), .sdata(so), .en(wb ? enb : ena), .word(pw),
        .caps(caps), .en_caps(ecaps), .half(half), .en_seen(es));
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        if (n >= 20) check("pready", 0, 1);
        rd = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
        @(posedge pclk);
    endtask
    task rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(0, a, 0);
        check(name, rd, exp);
    endtask
    task start(input logic [7:0] ctl, input logic [7:0] prog, input logic [5:0] n,
               input logic [31:0] w);
        apb(1, `SSM_CTRL_ADDR, {24'h0, ctl});
        apb(1, `SSM_PROG_ADDR, {24'h0, prog});
        apb(1, `SSM_WORD_ADDR, w);
        apb(1, `SSM_CNT_ADDR, {26'h0, n});
        lr <= ctl[5]; pol <= ctl[7]; wb <= ctl[2];
        apb(1, `SSM_CMD_ADDR, 32'h1);
        // Clear the receiver once the enables show the levels set by the new start.
        clr <= 1;
        @(posedge pclk);
        clr <= 0;
    endtask
    task wait_idle;
        int n;
        n = 0;
        do begin apb(0, `SSM_CMD_ADDR, 0); n++; end while (rd[0] !== 1'b0 && n < 1000);
        check("busy", {31'h0, rd[0]}, 0);
        repeat (3) @(posedge pclk);
    endtask
    task finish_test;
        if (num_errors == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (50000) @(posedge pclk);
        num_errors++;
        finish_test;
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        check("ena rst", ena, 1);
        rchk("ctrl rst", `SSM_CTRL_ADDR, 0);
        rchk("cnt rst", `SSM_CNT_ADDR, 32'h20);
        rchk("stat rst", `SSM_CMD_ADDR, 32'h2);
        apb(0, 8'h40, 0);
        check("bad err", err, 1);
        check("bad data", rd, 0);
        // ------------------------------------------------------------------
        // Mode 1, fast clock, enable over bits, synthesizer a.
        // ------------------------------------------------------------------
        fa <= 1; fb <= 0; fc <= 1;
        start(8'h83, 8'h00, 6'd8, 32'hA5000000);
        repeat (20) @(posedge pclk);
        check("enb idle", enb, 1);
        check("gain", {ghi, glo}, {fb, fa});
        wait_idle;
        check("word a", pw[7:0], 8'hA5);
        check("caps a", caps, 8);
        check("encap a", ecaps, 8);
        check("half fast", half, `SSM_FAST_HALF);
        rchk("ctrl rb", `SSM_CTRL_ADDR, 32'h83);
        start(8'h83, 8'h10, 6'd1, 32'h0);
        repeat (10) @(posedge pclk);
        check("ena dis", ena, 0);
        wait_idle;
        check("dis seen", es, 0);
        // ------------------------------------------------------------------
        // Mode 2, slow clock, enable after bits, synthesizer b, count 0.
        // ------------------------------------------------------------------
        fb <= 1; fc <= 1;
        start(8'hE4, 8'h02, 6'd0, 32'h12345678);
        repeat (40) @(posedge pclk);
        check("gate lo", glo, enb & fa);
        rchk("stat busy", `SSM_CMD_ADDR, 32'h5);
        wait_idle;
        check("word b", pw, 32'h12345678);
        check("caps b", caps, 32);
        check("encap b", ecaps, 0);
        check("en late", es, 1);
        check("half slow", half, `SSM_SLOW_HALF);
        for (int i = 0; i < 2; i++) begin
            fa <= i[0]; fb <= ~i[0]; fc <= i[0];
            repeat (3) @(posedge pclk);
            check("idle pins", {so, sc, glo}, {fb, fc, fa});
        end
        // ------------------------------------------------------------------
        // Every pin-mode code.
        // ------------------------------------------------------------------
        for (int m = 0; m < 4; m++) begin
            apb(1, `SSM_PROG_ADDR, m);
            rchk("mode", `SSM_CMD_ADDR, (m < 2) ? 32'h2 : m * 2);
        end
        fb <= 1;
        repeat (3) @(posedge pclk);
        check("m3 hi", ghi, 0);
        check("m3 lo", glo, fa);
        finish_test;
    end
endmodule
